// >>> src/ebmc_top.v
// External bank memory controller with Wishbone register slave
// Notes on behaviour
// - Bytes are always big-endian: the lowest address holds the top byte.
// - The system address is 25 bits wide, a 32 MB space.
// - Each bank drives 18 address lines, 256 KB physically per bank.
// - Bank windows sit anywhere in the space in 1 MB steps.
// - The base configuration register places the register area, reset 1FF1h.
// - Three bank control registers each set up one chip-select.
// - The three phase fields give 0 to 7 cycles each.
// - Access field zero disables the bank; n gives n+1 cycles.
// - The base field holds the bank start in 1 MB units, 0 to 1Fh.
// - In internal boot mode the first chip-select serves a plain device.
// - Reads inside the internal flash return flash, not the first bank.
// - In external boot mode the first chip-select is the boot memory.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "ebmc_defs.vh"
module ebmc_top
#(
   parameter SYS_AW = 25,
   parameter EXT_AW = 18
)
(
   input  wire              clk_i,                  // System clock
   input  wire              rst_i,                  // Sync reset, high
   input  wire              wb_cyc_i,               // Bus cycle
   input  wire              wb_stb_i,               // Bus strobe
   input  wire              wb_we_i,                // Bus write
   input  wire [15:0]       wb_adr_i,               // Byte address
   input  wire [3:0]        wb_sel_i,               // Byte lanes
   input  wire [31:0]       wb_dat_i,               // Write data
   output reg  [31:0]       wb_dat_o,               // Read data
   output reg               wb_ack_o,               // Acknowledge
   input  wire [1:0]        boot_mode_pins_i,       // Boot mode straps
   input  wire              cpu_req_i,              // Access request
   input  wire              cpu_we_i,               // Access is write
   input  wire [SYS_AW-1:0] cpu_adr_i,              // System address
   input  wire [31:0]       cpu_wdata_i,            // Write word
   output reg               cpu_ack_o,              // Access done pulse
   output reg  [31:0]       cpu_rdata_o,            // Read word
   output reg  [1:0]        cpu_tgt_o,              // Decoded target
   output reg  [EXT_AW-1:0] ext_adr_o,              // External address
   input  wire [7:0]        ext_dat_i,              // Data pin in
   output reg  [7:0]        ext_dat_o,              // Data pin out
   output reg               ext_dat_oe_o,           // Data pin enable
   output reg               chip_select_first_n_o,  // Bank 0 select
   output reg               chip_select_second_n_o, // Bank 1 select
   output reg               chip_select_third_n_o,  // Bank 2 select
   output reg               ext_oe_n_o,             // Output enable
   output reg               ext_we_n_o              // Write enable
);

localparam S_IDLE = 6'b000001;
localparam S_ADDR = 6'b000010;
localparam S_CSSU = 6'b000100;
localparam S_ACC  = 6'b001000;
localparam S_HOLD = 6'b010000;
localparam S_DONE = 6'b100000;

////////////////////////////////////////////////////////////////////////
// Registers
reg  [12:0]       sfr_cfg_ff;
reg  [31:0]       bank_ctl_ff [0:2];
reg  [1:0]        boot_mode_ff;
reg  [5:0]        state_ff;
reg  [3:0]        cnt_ff;
reg  [1:0]        bank_ff;
reg  [1:0]        idx_ff;
reg  [SYS_AW-1:0] adr_ff;
reg               we_ff;
reg  [31:0]       wdat_ff;
reg  [31:0]       rdat_ff;
reg  [5:0]        nxt_state;
reg  [3:0]        nxt_cnt;
reg  [1:0]        nxt_bank;
reg  [1:0]        nxt_idx;
reg  [SYS_AW-1:0] nxt_adr;
reg               nxt_we;
reg  [31:0]       nxt_wdat;
reg  [31:0]       nxt_rdat;
reg               nxt_ack;
reg  [1:0]        nxt_tgt;
reg  [1:0]        dec_bank;
reg  [1:0]        dec_tgt;
reg  [31:0]       bank_word;
reg  [31:0]       rd_word;
integer           i;
integer           b;

wire        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire        wb_wr   = wb_req & wb_we_i;
wire [31:0] sel_ctl = bank_ctl_ff[bank_ff];
wire [3:0]  tacs    = {1'b0, sel_ctl[`EBMC_F_TACS]};
wire [3:0]  tcos    = {1'b0, sel_ctl[`EBMC_F_TCOS]};
wire [3:0]  tcoh    = {1'b0, sel_ctl[`EBMC_F_TCOH]};
wire [3:0]  tacc    = {1'b0, sel_ctl[`EBMC_F_TACC]};
wire        busy    = ~state_ff[0];

////////////////////////////////////////////////////////////////////////
// First phase of a byte, skipping phases programmed to zero
function [5:0] ebmc_first;
   input [31:0] ctl;
   begin
      if (ctl[`EBMC_F_TACS] != 3'h0)
         ebmc_first = S_ADDR;
      else if (ctl[`EBMC_F_TCOS] != 3'h0)
         ebmc_first = S_CSSU;
      else
         ebmc_first = S_ACC;
   end
endfunction

////////////////////////////////////////////////////////////////////////
// Address decode of a new request
always @*
begin
   dec_tgt   = `EBMC_TGT_NONE;
   dec_bank  = 2'h0;
   bank_word = 32'h00000000;
   if (cpu_adr_i[`EBMC_A_SFR] == sfr_cfg_ff)
      dec_tgt = `EBMC_TGT_SFR;
   else if (~cpu_we_i && cpu_adr_i[`EBMC_A_FLASH] == `EBMC_FLASH_LOW &&
            ((boot_mode_ff == `EBMC_BOOT_INT &&
              cpu_adr_i[`EBMC_A_MB] == `EBMC_FLASH_MB_INT) ||
             (boot_mode_ff == `EBMC_BOOT_EXT &&
              cpu_adr_i[`EBMC_A_MB] == `EBMC_FLASH_MB_EXT)))
      dec_tgt = `EBMC_TGT_FLASH;
   else
   begin
      // Lowest bank wins on overlap; bank 0 is boot or plain device
      for (b = 2; b >= 0; b = b - 1)
      begin
         bank_word = bank_ctl_ff[b];
         if (bank_word[`EBMC_F_TACC] != 3'h0 &&
             {3'h0, cpu_adr_i[`EBMC_A_MB]} >=
                bank_word[`EBMC_F_BASE] &&
             {3'h0, cpu_adr_i[`EBMC_A_MB]} <=
                bank_word[`EBMC_F_END])
         begin
            dec_tgt  = `EBMC_TGT_EXT;
            dec_bank = b[1:0];
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Access sequencer
always @*
begin
   nxt_state = state_ff;
   nxt_cnt   = cnt_ff + 4'h1;
   nxt_bank  = bank_ff;
   nxt_idx   = idx_ff;
   nxt_adr   = adr_ff;
   nxt_we    = we_ff;
   nxt_wdat  = wdat_ff;
   nxt_rdat  = rdat_ff;
   nxt_ack   = 1'b0;
   nxt_tgt   = cpu_tgt_o;
   case (state_ff)
      S_IDLE:
      begin
         nxt_cnt = 4'h0;
         if (cpu_req_i && !cpu_ack_o)
         begin
            nxt_tgt = dec_tgt;
            if (dec_tgt == `EBMC_TGT_EXT)
            begin
               nxt_bank  = dec_bank;
               nxt_idx   = 2'h0;
               nxt_adr   = cpu_adr_i;
               nxt_we    = cpu_we_i;
               nxt_wdat  = cpu_wdata_i;
               nxt_state = ebmc_first(bank_ctl_ff[dec_bank]);
            end
            else
            begin
               // Internal targets are answered at once, data elsewhere
               nxt_ack  = 1'b1;
               nxt_rdat = 32'h00000000;
            end
         end
      end
      S_ADDR:
         if (cnt_ff == tacs - 4'h1)
         begin
            nxt_cnt   = 4'h0;
            nxt_state = (tcos != 4'h0) ? S_CSSU : S_ACC;
         end
      S_CSSU:
         if (cnt_ff == tcos - 4'h1)
         begin
            nxt_cnt   = 4'h0;
            nxt_state = S_ACC;
         end
      S_ACC:
         if (cnt_ff == tacc)
         begin
            nxt_cnt  = 4'h0;
            nxt_rdat = {rdat_ff[23:0], ext_dat_i};
            if (tcoh != 4'h0)
               nxt_state = S_HOLD;
            else if (idx_ff == `EBMC_LAST_BYTE)
               nxt_state = S_DONE;
            else
            begin
               nxt_idx   = idx_ff + 2'h1;
               nxt_state = ebmc_first(sel_ctl);
            end
         end
      S_HOLD:
         if (cnt_ff == tcoh - 4'h1)
         begin
            nxt_cnt = 4'h0;
            if (idx_ff == `EBMC_LAST_BYTE)
               nxt_state = S_DONE;
            else
            begin
               nxt_idx   = idx_ff + 2'h1;
               nxt_state = ebmc_first(sel_ctl);
            end
         end
      S_DONE:
      begin
         nxt_ack   = 1'b1;
         nxt_state = S_IDLE;
      end
      default:
         nxt_state = S_IDLE;
   endcase
end

wire nxt_sel = nxt_state[2] | nxt_state[3] | nxt_state[4];
wire nxt_run = nxt_state[1] | nxt_sel;

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      boot_mode_ff           <= boot_mode_pins_i;
      state_ff               <= S_IDLE;
      cnt_ff                 <= 4'h0;
      bank_ff                <= 2'h0;
      idx_ff                 <= 2'h0;
      adr_ff                 <= {SYS_AW{1'b0}};
      we_ff                  <= 1'b0;
      wdat_ff                <= 32'h00000000;
      rdat_ff                <= 32'h00000000;
      cpu_ack_o              <= 1'b0;
      cpu_rdata_o            <= 32'h00000000;
      cpu_tgt_o              <= `EBMC_TGT_NONE;
      ext_adr_o              <= {EXT_AW{1'b0}};
      ext_dat_o              <= 8'h00;
      ext_dat_oe_o           <= 1'b0;
      chip_select_first_n_o  <= 1'b1;
      chip_select_second_n_o <= 1'b1;
      chip_select_third_n_o  <= 1'b1;
      ext_oe_n_o             <= 1'b1;
      ext_we_n_o             <= 1'b1;
   end
   else
   begin
      state_ff               <= nxt_state;
      cnt_ff                 <= nxt_cnt;
      bank_ff                <= nxt_bank;
      idx_ff                 <= nxt_idx;
      adr_ff                 <= nxt_adr;
      we_ff                  <= nxt_we;
      wdat_ff                <= nxt_wdat;
      rdat_ff                <= nxt_rdat;
      cpu_ack_o              <= nxt_ack;
      cpu_rdata_o            <= nxt_rdat;
      cpu_tgt_o              <= nxt_tgt;
      ext_adr_o              <= {nxt_adr[`EBMC_A_WORD], nxt_idx};
      ext_dat_o              <= nxt_wdat[8*(3-nxt_idx) +: 8];
      ext_dat_oe_o           <= nxt_we & nxt_run;
      chip_select_first_n_o  <= ~(nxt_sel && nxt_bank == 2'h0);
      chip_select_second_n_o <= ~(nxt_sel && nxt_bank == 2'h1);
      chip_select_third_n_o  <= ~(nxt_sel && nxt_bank == 2'h2);
      ext_oe_n_o             <= ~(nxt_state[3] & ~nxt_we);
      ext_we_n_o             <= ~(nxt_state[3] & nxt_we);
   end
end

////////////////////////////////////////////////////////////////////////
// Register slave
always @*
begin
   case (wb_adr_i)
      `EBMC_OFS_SFR_CFG: rd_word = {19'h00000, sfr_cfg_ff};
      `EBMC_OFS_BANK0:   rd_word = bank_ctl_ff[0];
      `EBMC_OFS_BANK1:   rd_word = bank_ctl_ff[1];
      `EBMC_OFS_BANK2:   rd_word = bank_ctl_ff[2];
      `EBMC_OFS_STATUS:  rd_word = {24'h000000, boot_mode_ff,
                                    cpu_tgt_o, bank_ff, idx_ff[0], busy};
      default:           rd_word = 32'h00000000;
   endcase
end

always @(posedge clk_i)
begin
   if (rst_i)
   begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h00000000;
      sfr_cfg_ff     <= `EBMC_RST_SFR_CFG;
      bank_ctl_ff[0] <= `EBMC_RST_BANK0;
      bank_ctl_ff[1] <= `EBMC_RST_BANK1;
      bank_ctl_ff[2] <= `EBMC_RST_BANK2;
   end
   else
   begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h00000000;
      if (wb_wr && wb_adr_i == `EBMC_OFS_SFR_CFG)
      begin
         if (wb_sel_i[0])
            sfr_cfg_ff[7:0] <= wb_dat_i[7:0];
         if (wb_sel_i[1])
            sfr_cfg_ff[12:8] <= wb_dat_i[12:8];
      end
      for (i = 0; i < 3; i = i + 1)
         if (wb_wr && wb_adr_i == `EBMC_OFS_BANK0 + 16'h0004 * i)
            bank_ctl_ff[i] <= ((bank_ctl_ff[i] &
               ~{{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}) |
               (wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}))
               & `EBMC_BANK_MASK;
   end
end

endmodule

// >>> include/ebmc_defs.vh
// Constants of the external bank memory controller
`ifndef EBMC_DEFS_VH
`define EBMC_DEFS_VH
`define EBMC_OFS_SFR_CFG  16'h3000
`define EBMC_OFS_BANK0    16'h4000
`define EBMC_OFS_BANK1    16'h4004
`define EBMC_OFS_BANK2    16'h4008
`define EBMC_OFS_STATUS   16'h400C
`define EBMC_RST_SFR_CFG  13'h1FF1
`define EBMC_RST_BANK0    32'h08003000
`define EBMC_RST_BANK1    32'h0C083000
`define EBMC_RST_BANK2    32'h100C3000
`define EBMC_BANK_MASK    32'hFFFF3FFC
`define EBMC_F_TCOS       4:2
`define EBMC_F_TACS       7:5
`define EBMC_F_TCOH       10:8
`define EBMC_F_TACC       13:11
`define EBMC_F_BASE       23:16
`define EBMC_F_END        31:24
`define EBMC_A_MB         24:20
`define EBMC_A_SFR        24:12
`define EBMC_A_WORD       17:2
`define EBMC_A_FLASH      19:18
`define EBMC_FLASH_LOW    2'h0
`define EBMC_FLASH_MB_INT 5'h00
`define EBMC_FLASH_MB_EXT 5'h1F
`define EBMC_BOOT_INT     2'h0
`define EBMC_BOOT_EXT     2'h1
`define EBMC_TGT_EXT      2'h0
`define EBMC_TGT_FLASH    2'h1
`define EBMC_TGT_SFR      2'h2
`define EBMC_TGT_NONE     2'h3
`define EBMC_LAST_BYTE    2'h3
`endif

// >>> tb/ebmc_ext_mem.sv
// Byte-wide external memory model with phase counters
`timescale 1ns/100ps
module ebmc_ext_mem
(
   input  wire logic        clk_i,    // Clock
   input  wire logic        cs_n_i,   // Any select, low
   input  wire logic        oe_n_i,   // Output enable, low
   input  wire logic        we_n_i,   // Write enable, low
   input  wire logic [17:0] adr_i,    // Device address
   input  wire logic [7:0]  dat_i,    // Data from controller
   input  wire logic        dat_oe_i, // Controller drives
   output wire logic [7:0]  dat_o,    // Data to controller
   output logic      [3:0]  cos_o,    // Select-to-enable cycles
   output logic      [3:0]  acc_o,    // Enable-low cycles
   output logic      [3:0]  coh_o     // Hold cycles
);
   logic [7:0] mem [0:255];
   logic [7:0] last_ff;
   logic [3:0] cnt_ff;
   logic [1:0] ph_ff;
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = i[7:0] ^ 8'hA5;
      last_ff = 8'h00;
      cnt_ff = 4'h0;
      ph_ff = 2'h0;
   end
   // Released bus shows the inverse of the last byte
   assign dat_o = (!cs_n_i && !oe_n_i) ? mem[adr_i[7:0]] : ~last_ff;
   ////////////////////////////////////////////////////////////////////
   always @(posedge clk_i)
   begin
      if (!cs_n_i && !oe_n_i)
         last_ff <= dat_o;
      if (!cs_n_i && !we_n_i && dat_oe_i)
         mem[adr_i[7:0]] <= dat_i;
      if (cs_n_i)
      begin
         if (ph_ff == 2'h2)
            coh_o <= cnt_ff;
         if (ph_ff == 2'h1)
         begin
            acc_o <= cnt_ff;
            coh_o <= 4'h0;
         end
         ph_ff <= 2'h0;
         cnt_ff <= 4'h0;
      end
      else if (ph_ff == 2'h0 && !oe_n_i)
      begin
         cos_o <= cnt_ff;
         cnt_ff <= 4'h1;
         ph_ff <= 2'h1;
      end
      else if (ph_ff == 2'h1 && oe_n_i)
      begin
         acc_o <= cnt_ff;
         cnt_ff <= 4'h1;
         ph_ff <= 2'h2;
      end
      else
         cnt_ff <= cnt_ff + 4'h1;
   end
endmodule

// >>> tb/ebmc_top_monitor.sv
// Checker on the ports of the bank memory controller
`timescale 1ns/100ps
module ebmc_top_monitor
#(
   parameter EXT_AW = 18
)
(
   input wire logic              clk_i,                  // Clock
   input wire logic              rst_i,                  // Reset
   input wire logic              wb_cyc_i,               // Cycle
   input wire logic              wb_stb_i,               // Strobe
   input wire logic              wb_ack_o,               // Ack
   input wire logic [31:0]       wb_dat_o,               // Read data
   input wire logic              cpu_req_i,              // Request
   input wire logic              cpu_ack_o,              // Done
   input wire logic [1:0]        cpu_tgt_o,              // Target
   input wire logic [31:0]       cpu_rdata_o,            // Read word
   input wire logic [EXT_AW-1:0] ext_adr_o,              // Address
   input wire logic              ext_dat_oe_o,           // Drive
   input wire logic              chip_select_first_n_o,  // Select 0
   input wire logic              chip_select_second_n_o, // Select 1
   input wire logic              chip_select_third_n_o,  // Select 2
   input wire logic              ext_oe_n_o,             // Read enable
   input wire logic              ext_we_n_o              // Write enable
);
   wire [2:0] sel_n;
   assign sel_n = {chip_select_third_n_o, chip_select_second_n_o,
                   chip_select_first_n_o};
   default clocking mon_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_WB_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("register ack missing");
   AST_WB_QUIET: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_ONE_SEL: assert property ($onehot0(~sel_n))
      else $error("two selects low");
   AST_SEL_REQ: assert property (sel_n != 3'h7 |-> cpu_req_i)
      else $error("select without access");
   AST_OE_SEL: assert property (!ext_oe_n_o |-> sel_n != 3'h7)
      else $error("read enable without select");
   AST_OE_WE: assert property (!ext_oe_n_o |-> ext_we_n_o)
      else $error("read and write enable together");
   AST_DRV_RD: assert property (ext_dat_oe_o |-> ext_oe_n_o)
      else $error("data driven during read");
   // Byte index may step under a low enable when all side phases are zero
   AST_ADR_HELD: assert property (!ext_oe_n_o && !$past(ext_oe_n_o)
      |-> $stable(ext_adr_o[EXT_AW-1:2]))
      else $error("address moved in access");
   AST_ACK_PULSE: assert property (cpu_ack_o |=> !cpu_ack_o)
      else $error("done longer than one cycle");
   AST_ACK_BOUND: assert property ($rose(cpu_req_i)
      |-> ##[1:130] cpu_ack_o) else $error("access never done");
   AST_NONE_ZERO: assert property (cpu_ack_o && cpu_tgt_o == 2'h3
      |-> cpu_rdata_o == 32'h0) else $error("empty target data");
   AST_RST_IDLE: assert property ($fell(rst_i) |-> sel_n == 3'h7
      && !cpu_ack_o && !wb_ack_o) else $error("busy after reset");
endmodule

// >>> tb/test_ebmc_top.sv
// Register and access bench of the bank memory controller
`timescale 1ns/100ps
`include "ebmc_defs.vh"
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
      end \
   end
module test_ebmc_top;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cpu_req_i, cpu_we_i;
   logic [15:0] wb_adr_i;
   logic [3:0]  wb_sel_i, cos, acc, coh;
   logic [31:0] wb_dat_i, wb_dat_o, cpu_wdata_i, cpu_rdata_o, q;
   logic [1:0]  boot_mode_pins_i, cpu_tgt_o, t;
   logic [24:0] cpu_adr_i;
   logic [17:0] ext_adr_o;
   logic [7:0]  ext_dat_i, ext_dat_o;
   logic [2:0]  s;
   logic wb_ack_o, cpu_ack_o, ext_dat_oe_o, ext_oe_n_o, ext_we_n_o;
   logic chip_select_first_n_o, chip_select_second_n_o;
   logic chip_select_third_n_o;
   int bad_count = 0;
   int n_compared = 0;
   ebmc_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .boot_mode_pins_i, .cpu_req_i, .cpu_we_i, .cpu_adr_i, .cpu_wdata_i,
      .cpu_ack_o, .cpu_rdata_o, .cpu_tgt_o, .ext_adr_o, .ext_dat_i,
      .ext_dat_o, .ext_dat_oe_o, .chip_select_first_n_o,
      .chip_select_second_n_o, .chip_select_third_n_o, .ext_oe_n_o,
      .ext_we_n_o);
   ebmc_ext_mem mem_u (.clk_i, .cs_n_i(chip_select_first_n_o &
      chip_select_second_n_o & chip_select_third_n_o), .oe_n_i(ext_oe_n_o),
      .we_n_i(ext_we_n_o), .adr_i(ext_adr_o), .dat_i(ext_dat_o),
      .dat_oe_i(ext_dat_oe_o), .dat_o(ext_dat_i), .cos_o(cos), .acc_o(acc),
      .coh_o(coh));
   initial clk_i = 1'b0;
   always #10 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic rst_seq(input logic [1:0] m);
      boot_mode_pins_i <= m;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wb(input logic we, input logic [15:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 50)
      begin
         bad_count++;
         results();
      end
      @(posedge clk_i);
   endtask
   task automatic cpu(input logic we, input logic [24:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      s = 3'h0;
      cpu_req_i <= 1'b1;
      cpu_we_i <= we;
      cpu_adr_i <= a;
      cpu_wdata_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
         s = s | ~{chip_select_third_n_o, chip_select_second_n_o,
                   chip_select_first_n_o};
      end
      while (cpu_ack_o !== 1'b1 && n < 200);
      q = cpu_rdata_o;
      t = cpu_tgt_o;
      cpu_req_i <= 1'b0;
      if (n >= 200)
      begin
         bad_count++;
         results();
      end
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////////////////////////
   logic [15:0] ra [5] = '{16'h3000, 16'h4000, 16'h4004, 16'h4008,
                           16'h5000};
   logic [31:0] rv [5] = '{32'h1FF1, 32'h08003000, 32'h0C083000,
                           32'h100C3000, 32'h0};
   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, cpu_req_i, cpu_we_i} <= 5'h00;
      {wb_adr_i, wb_dat_i, cpu_adr_i, cpu_wdata_i} <= '0;
      wb_sel_i <= 4'hF;
      boot_mode_pins_i <= 2'h0;
      rst_i <= 1'b1;
      rst_seq(2'h0);
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, ra[i], 32'h0);
         `CHK("register reset", rv[i], q)
      end
      wb(1'b1, 16'h4008, 32'hFFFFFFFF);
      wb(1'b0, 16'h4008, 32'h0);
      `CHK("bank fields", 32'hFFFF3FFC, q)
      $display("register test done");
      cpu(1'b0, 25'h0000100, 32'h0);
      `CHK("flash read", {`EBMC_TGT_FLASH, 3'h0}, {t, s})
      cpu(1'b0, 25'h0040000, 32'h0);
      `CHK("bank0 read", {`EBMC_TGT_EXT, 3'h1}, {t, s})
      `CHK("wrapped word", 32'hA5A4A7A6, q)
      // Test windows sit above bank 0, which wins any overlap
      wb(1'b1, 16'h4004, 32'h09091928);
      cpu(1'b0, 25'h0900004, 32'h0);
      `CHK("bank1 read", {`EBMC_TGT_EXT, 3'h2}, {t, s})
      `CHK("bank1 word", 32'hA1A0A3A2, q)
      `CHK("phases", {4'h2, 4'h4, 4'h1}, {cos, acc, coh})
      cpu(1'b1, 25'h0900008, 32'h11223344);
      cpu(1'b0, 25'h0900008, 32'h0);
      `CHK("write back", 32'h11223344, q)
      $display("bank access test done");
      for (int n = 7; n >= 0; n--)
      begin
         wb(1'b1, 16'h4008, 32'h0B0B0020 | (n << 11));
         cpu(1'b0, 25'h0B00000, 32'h0);
         if (n > 0)
            `CHK("access time", n + 1, acc)
         `CHK("bank2 hit", n > 0 ? 5'h04 : 5'h18, {t, s})
      end
      cpu(1'b0, 25'h0A00000, 32'h0);
      `CHK("outside windows", {`EBMC_TGT_NONE, 3'h0}, {t, s})
      $display("timing test done");
      cpu(1'b0, 25'h1FF1000, 32'h0);
      `CHK("area at reset", `EBMC_TGT_SFR, t)
      wb(1'b1, 16'h3000, 32'h1FF2);
      cpu(1'b0, 25'h1FF2000, 32'h0);
      `CHK("moved area", `EBMC_TGT_SFR, t)
      cpu(1'b0, 25'h1FF1000, 32'h0);
      `CHK("old area", `EBMC_TGT_NONE, t)
      $display("register area test done");
      rst_seq(2'h1);
      cpu(1'b0, 25'h1F00100, 32'h0);
      `CHK("high flash", {`EBMC_TGT_FLASH, 3'h0}, {t, s})
      cpu(1'b0, 25'h0000100, 32'h0);
      `CHK("boot memory", {`EBMC_TGT_EXT, 3'h1}, {t, s})
      $display("boot mode test done");
      results();
   end
endmodule
bind ebmc_top ebmc_top_monitor #(.EXT_AW(EXT_AW)) mon_u (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .cpu_req_i, .cpu_ack_o,
   .cpu_tgt_o, .cpu_rdata_o, .ext_adr_o, .ext_dat_oe_o,
   .chip_select_first_n_o, .chip_select_second_n_o,
   .chip_select_third_n_o, .ext_oe_n_o, .ext_we_n_o);
